// file: include/spm_pkg.sv
package spm_pkg;
   // Register indexes and their byte addresses
   localparam logic [7:0] SPM_IDX_DATA = 8'h31;
   localparam logic [7:0] SPM_IDX_CTRL = 8'h32;
   localparam logic [7:0] SPM_IDX_STAT = 8'h33;
   localparam logic [7:0] SPM_ADDR_DATA = 8'(SPM_IDX_DATA << 2);
   localparam logic [7:0] SPM_ADDR_CTRL = 8'(SPM_IDX_CTRL << 2);
   localparam logic [7:0] SPM_ADDR_STAT = 8'(SPM_IDX_STAT << 2);
   // Control fields
   localparam int SPM_CR_IRQ_EN = 7;
   localparam int SPM_CR_OUT_EN = 6;
   localparam int SPM_CR_DIV_EN = 5;
   localparam int SPM_CR_MASTER = 4;
   localparam int SPM_CR_CLOCK_POLARITY = 3;
   localparam int SPM_CR_CLOCK_PHASE = 2;
   localparam int SPM_CR_RATE_HI = 1;
   localparam int SPM_CR_RATE_LO = 0;
   // Status fields
   localparam int SPM_SR_TCF = 7;
   localparam int SPM_SR_WRITE_COLLISION_FLAG = 6;
   localparam int SPM_SR_OVR = 5;
   localparam int SPM_SR_MODE_FAULT_FLAG = 4;
   localparam int SPM_SR_SOD = 2;
   localparam int SPM_SR_SSM = 1;
   localparam int SPM_SR_SSI = 0;
   // Reset values
   localparam logic [7:0] SPM_CTRL_RST = 8'h00;
   localparam logic [7:0] SPM_STAT_RST = 8'h00;
   localparam logic [7:0] SPM_DATA_RST = 8'h00;
   // Half SCK periods in pclk cycles, per rate code
   localparam logic [6:0] SPM_HALF_DIV4 = 7'h02;
   localparam logic [6:0] SPM_HALF_DIV8 = 7'h04;
   localparam logic [6:0] SPM_HALF_DIV16 = 7'h08;
   localparam logic [6:0] SPM_HALF_DIV32 = 7'h10;
   localparam logic [6:0] SPM_HALF_DIV64 = 7'h20;
   localparam logic [6:0] SPM_HALF_DIV128 = 7'h40;
   // Sixteen SCK edges per byte
   localparam logic [3:0] SPM_EDGE_LAST = 4'hF;
   localparam logic [3:0] SPM_EDGE_FIRST = 4'h0;
endpackage

// file: include/spm_shift_if.sv
`timescale 1ns/1ps
interface spm_shift_if;
   logic load;
   logic [7:0] load_byte;
   logic cap;
   logic shf;
   logic fin;
   logic rx_bit;
   logic [7:0] sr;
   modport ctl (output load, load_byte, cap, shf, fin, rx_bit, input sr);
   modport eng (input load, load_byte, cap, shf, fin, rx_bit, output sr);
endinterface

// file: logic/spm_shifter.sv
`timescale 1ns/1ps
module spm_shifter (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Commands from the controller
   spm_shift_if.eng sh
);
   typedef struct packed {
      logic [7:0] sr;
      logic cap_bit;
   } spm_shifter_state_t;

   spm_shifter_state_t q_r;
   spm_shifter_state_t q_nxt;

   // --------------------------------------------------
   // Shift engine
   // --------------------------------------------------
   // Captured bit waits for the shift edge so TX bit stays stable meanwhile
   always_comb begin
      q_nxt = q_r;
      if (sh.load) begin
         q_nxt.sr = sh.load_byte;
      end else if (sh.fin) begin
         q_nxt.sr = {q_r.sr[6:0], sh.rx_bit};
      end else begin
         if (sh.cap) begin
            q_nxt.cap_bit = sh.rx_bit;
         end
         if (sh.shf) begin
            q_nxt.sr = {q_r.sr[6:0], q_r.cap_bit};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign sh.sr = q_r.sr;
endmodule

// file: logic/spm_top.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
module spm_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial clock pin
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_n,
   // Master out pin
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_n,
   // Master in pin
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_n,
   // Slave select pin
   input wire logic ss_n_i,
   // Pin ownership and events
   output logic pin_func_en,
   output logic ss_pin_used,
   output logic irq,
   output logic wait_wake,
   output logic halt_wake
);
   generate
      if (ADDR_W < 8) begin : g_bad_addr
         $error("spm_top: ADDR_W must be at least 8");
      end
   endgenerate

   typedef enum logic [1:0] {
      SPM_REG_NONE = 2'b00,
      SPM_REG_DATA = 2'b01,
      SPM_REG_CTRL = 2'b10,
      SPM_REG_STAT = 2'b11
   } spm_reg_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic output_disable;
      logic soft_select_mode;
      logic internal_select_level;
      logic tcf;
      logic write_collision_flag;
      logic overrun_flag;
      logic mode_fault_flag;
      logic tcf_arm;
      logic mode_fault_flag_arm;
      logic [7:0] rxbuf;
      logic run;
      logic [3:0] edg;
      logic [6:0] div;
      logic sck;
      logic done;
      logic [2:0] sck_s;
      logic [1:0] ss_s;
      logic [1:0] mosi_s;
      logic [1:0] miso_s;
      logic [7:0] rdata;
   } spm_top_state_t;

   spm_top_state_t q_r;
   spm_top_state_t q_nxt;

   spm_shift_if sh ();

   spm_shifter u_shifter (
      .pclk (pclk),
      .presetn (presetn),
      .sh (sh)
   );

   // --------------------------------------------------
   // Helpers
   // --------------------------------------------------
   function automatic spm_reg_t spm_decode(input logic [ADDR_W-1:0] a);
      spm_reg_t r;
      r = SPM_REG_NONE;
      if (a == ADDR_W'(spm_pkg::SPM_ADDR_DATA)) begin
         r = SPM_REG_DATA;
      end else if (a == ADDR_W'(spm_pkg::SPM_ADDR_CTRL)) begin
         r = SPM_REG_CTRL;
      end else if (a == ADDR_W'(spm_pkg::SPM_ADDR_STAT)) begin
         r = SPM_REG_STAT;
      end
      return r;
   endfunction

   // Codes 101 and 111 are undefined; they fall to the slowest rate
   function automatic logic [6:0] spm_half(input logic [2:0] code);
      logic [6:0] h;
      h = spm_pkg::SPM_HALF_DIV128;
      unique case (code)
         3'h4: h = spm_pkg::SPM_HALF_DIV4;
         3'h0: h = spm_pkg::SPM_HALF_DIV8;
         3'h1: h = spm_pkg::SPM_HALF_DIV16;
         3'h6: h = spm_pkg::SPM_HALF_DIV32;
         3'h2: h = spm_pkg::SPM_HALF_DIV64;
         3'h3: h = spm_pkg::SPM_HALF_DIV128;
         default: h = spm_pkg::SPM_HALF_DIV128;
      endcase
      return h;
   endfunction

   // --------------------------------------------------
   // Decoded controls
   // --------------------------------------------------
   spm_reg_t sel_reg;
   logic acc;
   logic wr;
   logic rd;
   logic data_wr;
   logic data_rd;
   logic ctrl_wr;
   logic stat_wr;
   logic stat_rd;
   logic stat_acc;
   logic out_en;
   logic master;
   logic clock_polarity;
   logic clock_phase;
   logic ss_int_n;
   logic slave_sel;
   logic busy;
   logic blocked;
   logic accept;
   logic collide;
   logic [6:0] half;
   logic tick;
   logic s_edge;
   logic edge_ev;
   logic last_edge;
   logic fault;

   assign sel_reg = spm_decode(paddr);
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign data_wr = wr & (sel_reg == SPM_REG_DATA);
   assign data_rd = rd & (sel_reg == SPM_REG_DATA);
   assign ctrl_wr = wr & (sel_reg == SPM_REG_CTRL);
   assign stat_wr = wr & (sel_reg == SPM_REG_STAT);
   assign stat_rd = rd & (sel_reg == SPM_REG_STAT);
   assign stat_acc = acc & (sel_reg == SPM_REG_STAT);

   assign out_en = q_r.ctrl[spm_pkg::SPM_CR_OUT_EN];
   assign master = q_r.ctrl[spm_pkg::SPM_CR_MASTER];
   assign clock_polarity = q_r.ctrl[spm_pkg::SPM_CR_CLOCK_POLARITY];
   assign clock_phase = q_r.ctrl[spm_pkg::SPM_CR_CLOCK_PHASE];

   // Pin select only after both sync stages
   assign ss_int_n = q_r.soft_select_mode ? q_r.internal_select_level : q_r.ss_s[1];
   assign slave_sel = out_en & ~master & ~ss_int_n;
   assign fault = out_en & master & ~ss_int_n;

   assign busy = q_r.run | (q_r.edg != spm_pkg::SPM_EDGE_FIRST);
   assign blocked = q_r.tcf & ~q_r.tcf_arm;
   assign accept = data_wr & ~blocked & ~busy;
   assign collide = data_wr & ~blocked & busy;

   // Rate bits only steer the master divider
   assign half = spm_half({q_r.ctrl[spm_pkg::SPM_CR_DIV_EN],
                           q_r.ctrl[spm_pkg::SPM_CR_RATE_HI],
                           q_r.ctrl[spm_pkg::SPM_CR_RATE_LO]});
   assign tick = q_r.run & (q_r.div == 7'(half - 7'h01));
   assign s_edge = slave_sel & (q_r.sck_s[1] ^ q_r.sck_s[2]);
   assign edge_ev = tick | s_edge;
   assign last_edge = edge_ev & (q_r.edg == spm_pkg::SPM_EDGE_LAST);

   // --------------------------------------------------
   // Shift engine commands
   // --------------------------------------------------
   // Even edges capture at phase 0, odd edges at phase 1
   assign sh.load = accept;
   assign sh.load_byte = pwdata[7:0];
   assign sh.rx_bit = master ? q_r.miso_s[1] : q_r.mosi_s[1];
   assign sh.cap = edge_ev & (q_r.edg[0] == clock_phase) & ~(clock_phase & last_edge);
   assign sh.fin = clock_phase & last_edge;
   assign sh.shf = edge_ev & (q_r.edg[0] != clock_phase) & (q_r.edg != spm_pkg::SPM_EDGE_FIRST);

   // --------------------------------------------------
   // Next state
   // --------------------------------------------------
   always_comb begin
      q_nxt = q_r;
      q_nxt.sck_s = {q_r.sck_s[1:0], sck_i};
      q_nxt.ss_s = {q_r.ss_s[0], ss_n_i};
      q_nxt.mosi_s = {q_r.mosi_s[0], mosi_i};
      q_nxt.miso_s = {q_r.miso_s[0], miso_i};
      q_nxt.done = last_edge;

      // Read data captured in setup; side effects use this snapshot
      if (psel & ~penable & ~pwrite) begin
         unique case (sel_reg)
            SPM_REG_DATA: q_nxt.rdata = q_r.rxbuf;
            SPM_REG_CTRL: q_nxt.rdata = q_r.ctrl;
            SPM_REG_STAT: q_nxt.rdata = {q_r.tcf, q_r.write_collision_flag, q_r.overrun_flag, q_r.mode_fault_flag,
                                         1'b0, q_r.output_disable, q_r.soft_select_mode, q_r.internal_select_level};
            SPM_REG_NONE: q_nxt.rdata = 8'h00;
         endcase
      end

      // Software writes
      if (ctrl_wr) begin
         q_nxt.ctrl = pwdata[7:0];
         if (q_r.mode_fault_flag & ~q_r.mode_fault_flag_arm) begin
            q_nxt.ctrl[spm_pkg::SPM_CR_OUT_EN] = 1'b0;
            q_nxt.ctrl[spm_pkg::SPM_CR_MASTER] = 1'b0;
         end
      end
      if (stat_wr) begin
         q_nxt.output_disable = pwdata[spm_pkg::SPM_SR_SOD];
         q_nxt.soft_select_mode = pwdata[spm_pkg::SPM_SR_SSM];
         q_nxt.internal_select_level = pwdata[spm_pkg::SPM_SR_SSI];
      end

      // Clearing sequences; sets below take priority
      if (stat_acc) begin
         q_nxt.tcf_arm = 1'b1;
      end
      if ((data_rd | data_wr) & q_r.tcf_arm) begin
         q_nxt.tcf = 1'b0;
         q_nxt.tcf_arm = 1'b0;
      end
      if (data_rd & q_r.tcf_arm) begin
         q_nxt.write_collision_flag = 1'b0;
      end
      if (stat_rd & q_r.rdata[spm_pkg::SPM_SR_OVR]) begin
         q_nxt.overrun_flag = 1'b0;
      end
      if (stat_rd & q_r.rdata[spm_pkg::SPM_SR_MODE_FAULT_FLAG]) begin
         q_nxt.mode_fault_flag_arm = 1'b1;
      end
      if (ctrl_wr & q_r.mode_fault_flag_arm) begin
         q_nxt.mode_fault_flag = 1'b0;
         q_nxt.mode_fault_flag_arm = 1'b0;
      end

      // Collision leaves the running byte alone
      if (collide) begin
         q_nxt.write_collision_flag = 1'b1;
      end

      // Master clock generation
      if (accept & master & out_en) begin
         q_nxt.run = 1'b1;
         q_nxt.div = 7'h00;
      end else if (tick) begin
         q_nxt.div = 7'h00;
         q_nxt.sck = ~q_r.sck;
         if (q_r.edg == spm_pkg::SPM_EDGE_LAST) begin
            q_nxt.run = 1'b0;
         end
      end else if (q_r.run) begin
         q_nxt.div = 7'(q_r.div + 7'h01);
      end else begin
         q_nxt.sck = clock_polarity;
      end

      // Edge counter shared by both modes
      if (edge_ev) begin
         q_nxt.edg = 4'(q_r.edg + 4'h1);
      end else if (~q_r.run & ~slave_sel) begin
         q_nxt.edg = spm_pkg::SPM_EDGE_FIRST;
      end

      // End of byte, one cycle after the last edge
      if (q_r.done) begin
         if (q_r.tcf) begin
            q_nxt.overrun_flag = 1'b1;
         end else begin
            q_nxt.rxbuf = sh.sr;
            q_nxt.tcf = 1'b1;
            q_nxt.tcf_arm = 1'b0;
         end
      end

      // Mode fault overrides the clock state, edge counter and OUT_EN/MASTER bits, including a same-cycle write
      if (fault) begin
         q_nxt.mode_fault_flag = 1'b1;
         q_nxt.ctrl[spm_pkg::SPM_CR_OUT_EN] = 1'b0;
         q_nxt.ctrl[spm_pkg::SPM_CR_MASTER] = 1'b0;
         q_nxt.run = 1'b0;
         q_nxt.edg = spm_pkg::SPM_EDGE_FIRST;
         q_nxt.div = 7'h00;
         q_nxt.sck = clock_polarity;
      end else if (~out_en) begin
         q_nxt.run = 1'b0;
         q_nxt.edg = spm_pkg::SPM_EDGE_FIRST;
      end
   end

   // --------------------------------------------------
   // State register
   // --------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= '0;
         q_r.ctrl <= spm_pkg::SPM_CTRL_RST;
         q_r.rxbuf <= spm_pkg::SPM_DATA_RST;
         q_r.sck_s <= 3'h0;
         q_r.ss_s <= 2'h3;
         q_r.mosi_s <= 2'h3;
         q_r.miso_s <= 2'h3;
      end else begin
         q_r <= q_nxt;
      end
   end

   // --------------------------------------------------
   // Outputs
   // --------------------------------------------------
   assign prdata = {24'h000000, q_r.rdata};
   assign pready = 1'b1;
   assign pslverr = acc & (sel_reg == SPM_REG_NONE);

   // Enables low while driving; pins are released whenever out_en is clear
   assign sck_o = q_r.sck;
   assign sck_oe_n = ~(out_en & master);
   assign mosi_o = sh.sr[7];
   assign mosi_oe_n = ~(out_en & master & ~q_r.output_disable);
   assign miso_o = sh.sr[7];
   assign miso_oe_n = ~(slave_sel & ~q_r.output_disable);
   assign pin_func_en = out_en;
   assign ss_pin_used = out_en & ~q_r.soft_select_mode;

   // Collision flag deliberately left out of the request
   assign irq = q_r.ctrl[spm_pkg::SPM_CR_IRQ_EN] & (q_r.tcf | q_r.mode_fault_flag | q_r.overrun_flag);
   assign wait_wake = irq;
   assign halt_wake = q_r.ctrl[spm_pkg::SPM_CR_IRQ_EN] & q_r.tcf;
endmodule

// file: sim/spm_sva.sv
`timescale 1ns/1ps
// ---
// Port checker
// ---
module spm_sva #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic sck_o,
   input wire logic sck_oe_n,
   input wire logic mosi_oe_n,
   input wire logic miso_oe_n,
   input wire logic ss_n_i,
   // Events
   input wire logic pin_func_en,
   input wire logic ss_pin_used,
   input wire logic irq,
   input wire logic wait_wake,
   input wire logic halt_wake
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence acc_s;
      psel && penable;
   endsequence
   sequence fault_s;
      ss_pin_used && !sck_oe_n && !ss_n_i;
   endsequence
   wake_same_a: assert property (wait_wake == irq) else $error("wait wake differs");
   halt_sub_a: assert property (halt_wake |-> irq) else $error("halt wake alone");
   ready_a: assert property (acc_s |-> pready) else $error("no ready");
   unmapped_a: assert property (acc_s ##0 !(paddr inside {8'hC4, 8'hC8, 8'hCC}) |-> pslverr)
      else $error("no slave error");
   sck_own_a: assert property (!sck_oe_n |-> pin_func_en) else $error("sck driven while off");
   mosi_own_a: assert property (!mosi_oe_n |-> !sck_oe_n) else $error("mosi driven as slave");
   miso_own_a: assert property (!miso_oe_n |-> sck_oe_n) else $error("miso driven as master");
   fault_a: assert property (fault_s |-> ##[1:6] sck_oe_n) else $error("no mode fault");
   pace_a: assert property (!sck_oe_n && $changed(sck_o) |=> $stable(sck_o)) else $error("sck too fast");
   upper_a: assert property (prdata[31:8] == 24'h000000) else $error("upper read bits set");
   irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable)) else $error("irq dropped");
endmodule
bind spm_top spm_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_oe_n(mosi_oe_n), .miso_oe_n(miso_oe_n),
   .ss_n_i(ss_n_i), .pin_func_en(pin_func_en), .ss_pin_used(ss_pin_used), .irq(irq),
   .wait_wake(wait_wake), .halt_wake(halt_wake));

// file: sim/spm_peer.sv
`timescale 1ns/1ps
// ---
// External slave
// ---
module spm_peer (
   // Link
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   output logic miso,
   // Setup
   input wire logic clock_phase,
   input wire logic [7:0] tx,
   output logic [7:0] rx
);
   int e = 0;
   initial rx = 8'h00;
   always @(negedge sel_n) begin
      e = 0;
      miso = tx[7];
   end
   // Released line flips so stale data never matches
   always @(posedge sel_n) begin
      miso = ~miso;
   end
   always @(sck) begin
      if (!sel_n && e < 16) begin
         if ((e % 2) == clock_phase) begin
            rx = {rx[6:0], mosi};
         end else if (((e + 1 - clock_phase) >> 1) < 8) begin
            miso = tx[7 - ((e + 1 - clock_phase) >> 1)];
         end
         e = e + 1;
      end
   end
endmodule

// file: sim/spm_top_test.sv
`timescale 1ns/1ps
module spm_top_test;
   localparam logic [7:0] DR = spm_pkg::SPM_ADDR_DATA;
   localparam logic [7:0] CR = spm_pkg::SPM_ADDR_CTRL;
   localparam logic [7:0] SR = spm_pkg::SPM_ADDR_STAT;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ss_n_i = 1'b1, sel_n = 1'b1;
   logic [7:0] paddr = 8'h00, tx = 8'h00, rx, cv, sv;
   logic ext_sck = 1'b0, ext_mosi = 1'b0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso, miso_o, miso_oe_n, v;
   logic pin_func_en, ss_pin_used, irq, wait_wake, halt_wake;
   logic [2:0] code [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
   int error_cnt = 0, checked = 0, n;
   spm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sck_i(sck_oe_n ? ext_sck : sck_o), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
      .mosi_i(mosi_oe_n ? ext_mosi : mosi_o), .mosi_o(mosi_o),
      .mosi_oe_n(mosi_oe_n), .miso_i(miso), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .ss_n_i(ss_n_i),
      .pin_func_en(pin_func_en), .ss_pin_used(ss_pin_used), .irq(irq), .wait_wake(wait_wake),
      .halt_wake(halt_wake));
   spm_peer u_peer (.sck(sck_o), .mosi(mosi_o), .sel_n(sel_n), .miso(miso), .clock_phase(cv[2]), .tx(tx), .rx(rx));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 64);
      if (pready !== 1'b1) begin
         error_cnt++;
         close_out();
      end
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(r[7:0], e);
   endtask
   // Bounded: a lost completion must not hang the run
   task automatic wirq;
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      if (irq !== 1'b1) begin
         error_cnt++;
         close_out();
      end
   endtask
   // External master, phase 0: half period of 6 pclk clears the sync latency
   task automatic sbyte(input logic [7:0] d, output logic [7:0] q);
      for (int b = 7; b >= 0; b--) begin
         ext_mosi <= d[b];
         repeat (6) @(posedge pclk);
         ext_sck <= 1'b1;
         q[b] = miso_o;
         repeat (6) @(posedge pclk);
         ext_sck <= 1'b0;
      end
   endtask
   initial begin
      cv = 8'h00;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(CR, 8'h00);
      rd(SR, 8'h00);
      rd(DR, 8'h00);
      rd(8'h00, 8'h00);
      $display("test reset done");
      xfer(1'b1, CR, 8'hD0);
      tx <= 8'h3C;
      sel_n <= 1'b0;
      xfer(1'b1, DR, 8'hA5);
      wirq();
      sel_n <= 1'b1;
      chk(rx, 8'hA5);
      rd(SR, 8'h80);
      rd(DR, 8'h3C);
      @(negedge pclk);
      chk({7'h0, irq}, 8'h00);
      $display("test exchange done");
      tx <= 8'h5A;
      sel_n <= 1'b0;
      xfer(1'b1, DR, 8'h11);
      wirq();
      xfer(1'b1, DR, 8'h22);
      repeat (120) @(posedge pclk);
      sel_n <= 1'b1;
      chk(rx, 8'h11);
      rd(SR, 8'h80);
      rd(DR, 8'h5A);
      $display("test blocked write done");
      tx <= 8'hC3;
      sel_n <= 1'b0;
      xfer(1'b1, DR, 8'h66);
      xfer(1'b1, DR, 8'h99);
      wirq();
      sel_n <= 1'b1;
      chk(rx, 8'h66);
      rd(SR, 8'hC0);
      rd(DR, 8'hC3);
      rd(SR, 8'h00);
      $display("test collision done");
      xfer(1'b1, SR, 8'h04);
      @(negedge pclk);
      chk({7'h0, mosi_oe_n}, 8'h01);
      chk({7'h0, sck_oe_n}, 8'h00);
      xfer(1'b1, SR, 8'h03);
      ss_n_i <= 1'b0;
      repeat (6) @(posedge pclk);
      chk({7'h0, sck_oe_n}, 8'h00);
      chk({7'h0, ss_pin_used}, 8'h00);
      chk({7'h0, mosi_oe_n}, 8'h00);
      ss_n_i <= 1'b1;
      xfer(1'b1, SR, 8'h00);
      $display("test pin control done");
      for (int i = 0; i < 6; i++) begin
         cv = {2'b11, code[i][2], 1'b1, i[0], i > 2, code[i][1:0]};
         xfer(1'b1, CR, cv & 8'hBF);
         xfer(1'b1, CR, cv);
         @(negedge pclk);
         chk({7'h0, sck_o}, {7'h0, cv[3]});
         xfer(1'b1, DR, 8'h00);
         for (int j = 0; j < 2; j++) begin
            v = sck_o;
            n = 0;
            while (sck_o === v && n < 300) begin
               @(posedge pclk);
               n++;
            end
         end
         chk(n[7:0], 8'(2 << i));
         wirq();
         xfer(1'b0, SR, 8'h00);
         xfer(1'b0, DR, 8'h00);
      end
      $display("test rates done");
      xfer(1'b1, CR, 8'h00);
      xfer(1'b1, CR, 8'hD0);
      ss_n_i <= 1'b0;
      repeat (6) @(posedge pclk);
      chk({7'h0, sck_oe_n}, 8'h01);
      chk({7'h0, irq}, 8'h01);
      rd(CR, 8'h80);
      xfer(1'b1, CR, 8'hD0);
      rd(CR, 8'h80);
      ss_n_i <= 1'b1;
      rd(SR, 8'h10);
      xfer(1'b1, CR, 8'hD0);
      rd(SR, 8'h00);
      rd(CR, 8'hD0);
      $display("test mode fault done");
      xfer(1'b1, CR, 8'hC0);
      xfer(1'b1, DR, 8'h96);
      ss_n_i <= 1'b0;
      repeat (4) @(posedge pclk);
      chk({7'h0, miso_oe_n}, 8'h00);
      chk({7'h0, sck_oe_n}, 8'h01);
      sbyte(8'h4B, sv);
      chk(sv, 8'h96);
      wirq();
      sbyte(8'hE1, sv);
      repeat (8) @(posedge pclk);
      ss_n_i <= 1'b1;
      rd(SR, 8'hA0);
      rd(DR, 8'h4B);
      rd(SR, 8'h00);
      $display("test slave overrun done");
      close_out();
   end
endmodule
